/* File: hdl/asq_pkg.sv */
// constants and types shared by the converter sequencer files
package asq_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int NUM_INPUTS = 13;
    localparam int IDX_W = 4;
    localparam int RAW_W = 12;
    localparam int WORD_W = 16;
    localparam int BUF_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int DADDR_W = 8;
    localparam int MAX_SH = 4;

    // throughput targets in samples per second
    localparam int RATE_10B_SPS = 1100000;
    localparam int RATE_12B_SPS = 500000;
    // longest allowed period per sample, rounded down
    localparam int PERIOD_10B_CYC = CLK_HZ / RATE_10B_SPS;
    localparam int PERIOD_12B_CYC = CLK_HZ / RATE_12B_SPS;
    // conversion lengths chosen to leave room for the sample phase
    localparam logic [5:0] CONV_10B_CYC = 6'(PERIOD_10B_CYC - 6);
    localparam logic [5:0] CONV_12B_CYC = 6'(PERIOD_12B_CYC - 6);

    localparam logic [2:0] TRIG_SOFT = 3'h0;
    localparam logic [2:0] TRIG_EXT_PIN = 3'h1;
    localparam logic [2:0] TRIG_TIMER_A = 3'h2;
    localparam logic [2:0] TRIG_TIMER_B = 3'h4;
    localparam logic [2:0] TRIG_AUTO = 3'h7;

    localparam logic [1:0] FMT_UNSIGNED = 2'h0;
    localparam logic [1:0] FMT_SIGNED = 2'h1;

    localparam int RES10_MSB = 9;
    localparam int RES12_MSB = 11;

    localparam logic [4:0] SAMPLE_TIME_RST = 5'h02;
    localparam logic [3:0] SMPI_RST = 4'h0;
    localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;
    localparam logic [IDX_W-1:0] IDX_LAST = 4'hc;

    typedef enum logic [2:0] {
        ASQ_IDLE = 3'h1,
        ASQ_SAMPLE = 3'h2,
        ASQ_CONVERT = 3'h4
    } asq_state_type;
endpackage

/* File: hdl/asq_result_format.sv */
// formats a raw conversion code into the result word
`timescale 1ns/1ps
module asq_result_format (
    input wire logic [asq_pkg::RAW_W-1:0] raw_code,
    input wire logic res_12b,
    input wire logic [1:0] fmt_sel,
    output logic [asq_pkg::WORD_W-1:0] word
);
    import asq_pkg::*;

    // signed form: offset binary to two's complement, then extend
    always_comb begin
        logic [WORD_W-1:0] mag;
        logic msb;
        mag = res_12b ? WORD_W'(raw_code) : WORD_W'(raw_code[RES10_MSB:0]);
        msb = res_12b ? raw_code[RES12_MSB] : raw_code[RES10_MSB];
        word = mag;
        if (fmt_sel == FMT_SIGNED) begin
            if (res_12b) begin
                word = {{(WORD_W-RES12_MSB){~msb}}, raw_code[RES12_MSB-1:0]};
            end else begin
                word = {{(WORD_W-RES10_MSB){~msb}}, raw_code[RES10_MSB-1:0]};
            end
        end else if (fmt_sel != FMT_UNSIGNED) begin
            // reserved codes give zero
            word = '0;
        end
    end
endmodule

/* File: hdl/asq_scan_pick.sv */
// picks the next enabled analog input of the scan list
`timescale 1ns/1ps
module asq_scan_pick (
    input wire logic [asq_pkg::NUM_INPUTS-1:0] scan_mask,
    input wire logic [asq_pkg::IDX_W-1:0] cur_idx,
    input wire logic from_start,
    output logic [asq_pkg::IDX_W-1:0] next_idx
);
    import asq_pkg::*;

    // wraps around; an empty mask falls back to input zero
    always_comb begin
        logic found;
        int cand;
        found = 1'b0;
        cand = 0;
        next_idx = IDX_ZERO;
        for (int k = 0; k < 2 * NUM_INPUTS; k++) begin
            cand = from_start ? k : (int'(cur_idx) + 1 + k);
            cand = cand % NUM_INPUTS;
            if (!found && scan_mask[cand]) begin
                found = 1'b1;
                next_idx = IDX_W'(cand);
            end
        end
    end
endmodule

/* File: hdl/asq_sequencer.sv */
// converter sequencer: sampling, conversion, result store and dma addressing
`timescale 1ns/1ps
// How it works
// - resolution_select picks 10-bit four-channel or 12-bit one-channel; reset is 10-bit
// - 12-bit converts one channel only; 10-bit holds up to four together
// - thirteen analog inputs, indices zero to twelve, plus two reference inputs
// - as dma source, one dma request each time the irq flag sets
// - samples_per_increment N advances dma pointer every N+1 conversions
// - build order set: dma address equals the stand-alone buffer address
// - build order clear: scatter address from input index and buffer size
// - same count sets the irq flag; raising the interrupt needs enable
// - with scanning on, scan list restarts at the count point
// - without dma: sixteen sequential buffers, pointer returns at count point
// - with dma: one result register, overwritten by the next conversion
// - done cleared at conversion start, set at end, held through sampling
// - pin reads digital only if both modules configure it digital, else zero
// - sustains 1.1 Msps at 10-bit and 500 ksps at 12-bit
// - trigger source 000 soft, 001 pin, 010/100 timers, 111 auto counter
// - auto-start resamples after conversion; otherwise software starts sampling
// - software may clear done, never set it; clearing leaves conversion running
// - result zero-extended (00) or sign-extended (01); other codes reserved
module asq_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic converter_on,
    input wire logic resolution_select,
    input wire logic [1:0] result_format_select,
    input wire logic [2:0] convert_trigger_source,
    input wire logic auto_sample_start,
    input wire logic [1:0] channel_count_select,
    input wire logic [3:0] samples_per_increment,
    input wire logic input_scan_enable,
    input wire logic [asq_pkg::NUM_INPUTS-1:0] scan_select,
    input wire logic [asq_pkg::IDX_W-1:0] ch0_input_select,
    input wire logic [4:0] auto_sample_cycles,
    input wire logic sample_start_write,
    input wire logic sample_end_write,
    input wire logic done_clear_write,
    input wire logic ext_pin_edge,
    input wire logic timer_a_match,
    input wire logic timer_b_match,
    input wire logic dma_present,
    input wire logic dma_build_order_select,
    input wire logic [2:0] dma_buf_size_log2,
    input wire logic [asq_pkg::RAW_W-1:0] sar_code,
    input wire logic [asq_pkg::PTR_W-1:0] buf_read_index,
    input wire logic [asq_pkg::NUM_INPUTS-1:0] pin_analog_config,
    input wire logic [asq_pkg::NUM_INPUTS-1:0] peer_pin_analog_config,
    input wire logic [asq_pkg::NUM_INPUTS-1:0] pin_level,
    output logic sample_phase_bit,
    output logic conv_done,
    output logic converting,
    output logic [asq_pkg::IDX_W-1:0] ch0_input_active,
    output logic [1:0] sh_channel,
    output logic result_strobe,
    output logic [asq_pkg::WORD_W-1:0] result_word_first,
    output logic [asq_pkg::WORD_W-1:0] buf_read_data,
    output logic [asq_pkg::PTR_W-1:0] buf_pointer,
    output logic [asq_pkg::DADDR_W-1:0] dma_address,
    output logic converter_irq_flag,
    output logic dma_request,
    output logic [asq_pkg::NUM_INPUTS-1:0] digital_in
);
    import asq_pkg::*;

    asq_state_type state_q;
    logic sample_phase_bit_q;
    logic done_q;
    logic [5:0] cyc_q;
    logic [1:0] sh_q;
    logic [3:0] op_cnt_q;
    logic [IDX_W-1:0] scan_idx_q;
    logic scan_restart_q;
    logic [PTR_W-1:0] ptr_q;
    logic [DADDR_W-1:0] slot_q;
    logic [WORD_W-1:0] res_q;
    logic strobe_q;
    logic irq_q;
    logic dreq_q;
    logic [DADDR_W-1:0] daddr_q;
    logic [WORD_W-1:0] rd_q;
    logic [NUM_INPUTS-1:0] dig_q;
    logic [WORD_W-1:0] buf_mem [BUF_DEPTH];

    logic trig_hit;
    logic conv_last_cyc;
    logic last_sh;
    logic count_point;
    logic [IDX_W-1:0] scan_next;
    logic [WORD_W-1:0] fmt_word;

    // number of holding channels in use, minus one
    function automatic logic [1:0] sh_last(input logic res12, input logic [1:0] chps);
        if (res12 || chps == 2'h0) begin
            return 2'h0;
        end else if (chps == 2'h1) begin
            return 2'h1;
        end
        return 2'(MAX_SH - 1);
    endfunction

    // scatter slot mask for a power-of-two buffer size
    function automatic logic [DADDR_W-1:0] size_mask(input logic [2:0] lg);
        return DADDR_W'((9'h001 << lg) - 9'h001);
    endfunction

    asq_scan_pick u_scan (
        .scan_mask(scan_select),
        .cur_idx(scan_idx_q),
        .from_start(scan_restart_q),
        .next_idx(scan_next)
    );

    // resolution picks format width and length
    asq_result_format u_fmt (
        .raw_code(sar_code),
        .res_12b(resolution_select),
        .fmt_sel(result_format_select),
        .word(fmt_word)
    );

    always_comb begin
        case (convert_trigger_source)
            TRIG_SOFT: trig_hit = sample_end_write;
            TRIG_EXT_PIN: trig_hit = ext_pin_edge;
            TRIG_TIMER_A: trig_hit = timer_a_match;
            TRIG_TIMER_B: trig_hit = timer_b_match;
            TRIG_AUTO: trig_hit = (cyc_q >= {1'b0, auto_sample_cycles});
            default: trig_hit = 1'b0;
        endcase
    end

    assign conv_last_cyc = resolution_select ? (cyc_q == CONV_12B_CYC - 6'h01)
                                             : (cyc_q == CONV_10B_CYC - 6'h01);
    // 12-bit stops after the first holding channel
    assign last_sh = (sh_q == sh_last(resolution_select, channel_count_select));
    assign count_point = (state_q == ASQ_CONVERT) && conv_last_cyc
                         && (op_cnt_q == samples_per_increment);

    // sequencing state and cycle counting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ASQ_IDLE;
            cyc_q <= '0;
            sh_q <= '0;
        end else if (!converter_on) begin
            state_q <= ASQ_IDLE;
            cyc_q <= '0;
            sh_q <= '0;
        end else begin
            case (state_q)
                ASQ_IDLE: begin
                    cyc_q <= '0;
                    sh_q <= '0;
                    if (auto_sample_start || sample_start_write) begin
                        state_q <= ASQ_SAMPLE;
                    end
                end
                ASQ_SAMPLE: begin
                    if (trig_hit) begin
                        state_q <= ASQ_CONVERT;
                        cyc_q <= '0;
                    end else begin
                        cyc_q <= cyc_q + 6'h01;
                    end
                end
                ASQ_CONVERT: begin
                    if (conv_last_cyc) begin
                        cyc_q <= '0;
                        if (last_sh) begin
                            sh_q <= '0;
                            state_q <= auto_sample_start ? ASQ_SAMPLE : ASQ_IDLE;
                        end else begin
                            sh_q <= sh_q + 2'h1;
                        end
                    end else begin
                        cyc_q <= cyc_q + 6'h01;
                    end
                end
                default: begin
                    state_q <= ASQ_IDLE;
                    cyc_q <= '0;
                    sh_q <= '0;
                end
            endcase
        end
    end

    // sample bit mirrors the sample phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_phase_bit_q <= 1'b0;
        end else if (!converter_on) begin
            sample_phase_bit_q <= 1'b0;
        end else if (state_q == ASQ_IDLE) begin
            sample_phase_bit_q <= auto_sample_start || sample_start_write;
        end else if (state_q == ASQ_SAMPLE) begin
            sample_phase_bit_q <= !trig_hit;
        end else if (state_q == ASQ_CONVERT) begin
            sample_phase_bit_q <= conv_last_cyc && last_sh && auto_sample_start;
        end
    end

    // done flag; hardware set beats software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else if (state_q == ASQ_CONVERT && conv_last_cyc && last_sh) begin
            done_q <= 1'b1;
        end else if (state_q == ASQ_SAMPLE && trig_hit && converter_on) begin
            done_q <= 1'b0;
        end else if (done_clear_write) begin
            done_q <= 1'b0;
        end
    end

    // operation counter toward the count point
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_cnt_q <= SMPI_RST;
        end else if (!converter_on) begin
            op_cnt_q <= SMPI_RST;
        end else if (state_q == ASQ_CONVERT && conv_last_cyc) begin
            op_cnt_q <= count_point ? SMPI_RST : op_cnt_q + 4'h1;
        end
    end

    // scan position, restarted at the count point
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_idx_q <= IDX_ZERO;
            scan_restart_q <= 1'b1;
        end else if (!converter_on || !input_scan_enable) begin
            scan_idx_q <= IDX_ZERO;
            scan_restart_q <= 1'b1;
        end else if (state_q == ASQ_SAMPLE && trig_hit) begin
            // picker never leaves zero to twelve
            scan_idx_q <= scan_next;
            scan_restart_q <= 1'b0;
        end else if (count_point) begin
            scan_restart_q <= 1'b1;
        end
    end

    // sequential buffer pointer, home at the count point
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= '0;
        end else if (!converter_on) begin
            ptr_q <= '0;
        end else if (state_q == ASQ_CONVERT && conv_last_cyc) begin
            ptr_q <= count_point ? '0 : ptr_q + 4'h1;
        end
    end

    // dma slot advances once per count point
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_q <= '0;
        end else if (!converter_on) begin
            slot_q <= '0;
        end else if (count_point) begin
            slot_q <= (slot_q + 8'h01) & size_mask(dma_buf_size_log2);
        end
    end

    // stand-alone buffer; dma parts keep only the single register
    always_ff @(posedge clk) begin
        if (state_q == ASQ_CONVERT && conv_last_cyc && !dma_present) begin
            buf_mem[ptr_q] <= fmt_word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else begin
            rd_q <= buf_mem[buf_read_index];
        end
    end

    // single result register, overwritten each conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_q <= '0;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= state_q == ASQ_CONVERT && conv_last_cyc;
            if (state_q == ASQ_CONVERT && conv_last_cyc) begin
                res_q <= fmt_word;
            end
        end
    end

    // ordered address follows the buffer pointer
    // scatter address from input index and size
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            daddr_q <= '0;
        end else if (state_q == ASQ_CONVERT && conv_last_cyc) begin
            if (dma_build_order_select) begin
                daddr_q <= DADDR_W'(ptr_q);
            end else if (sh_q == 2'h0) begin
                daddr_q <= DADDR_W'(DADDR_W'(ch0_input_active) << dma_buf_size_log2) | slot_q;
            end else begin
                daddr_q <= DADDR_W'(DADDR_W'(sh_q) << dma_buf_size_log2) | slot_q;
            end
        end
    end

    // one-cycle flag pulse to irq and dma together
    // dma request on each flag set while dma_present is high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            dreq_q <= 1'b0;
        end else begin
            irq_q <= count_point;
            dreq_q <= count_point && dma_present;
        end
    end

    // digital only when both modules agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dig_q <= '0;
        end else begin
            dig_q <= pin_level & pin_analog_config & peer_pin_analog_config;
        end
    end

    assign ch0_input_active = input_scan_enable ? scan_idx_q : ch0_input_select;
    assign sample_phase_bit = sample_phase_bit_q;
    assign conv_done = done_q;
    assign converting = state_q[2];
    assign sh_channel = sh_q;
    assign result_strobe = strobe_q;
    assign result_word_first = res_q;
    assign buf_read_data = rd_q;
    assign buf_pointer = ptr_q;
    assign dma_address = daddr_q;
    assign converter_irq_flag = irq_q;
    assign dma_request = dreq_q;
    assign digital_in = dig_q;
endmodule

/* File: verif/asq_dma_model.sv */
// dma controller and interrupt logic facing the converter sequencer
`timescale 1ns/1ps
module asq_dma_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dma_request,
    input wire logic converter_irq_flag,
    input wire logic [asq_pkg::DADDR_W-1:0] dma_address,
    input wire logic [asq_pkg::WORD_W-1:0] result_word_first,
    output int req_count,
    output int irq_count,
    output logic [asq_pkg::DADDR_W-1:0] last_addr,
    output logic [asq_pkg::WORD_W-1:0] read_word
);
    import asq_pkg::*;
    // one transfer per request
    // read in the request cycle, before the next result overwrites it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_count <= 0;
            last_addr <= '0;
            read_word <= '0;
        end else if (dma_request) begin
            req_count <= req_count + 1;
            last_addr <= dma_address;
            read_word <= result_word_first;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_count <= 0;
        end else if (converter_irq_flag) begin
            irq_count <= irq_count + 1;
        end
    end
endmodule

/* File: verif/asq_sequencer_sva.sv */
// port assertions for the converter sequencer
`timescale 1ns/1ps
module asq_sequencer_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic converter_on,
    input wire logic resolution_select,
    input wire logic auto_sample_start,
    input wire logic done_clear_write,
    input wire logic dma_present,
    input wire logic dma_build_order_select,
    input wire logic sample_phase_bit,
    input wire logic conv_done,
    input wire logic converting,
    input wire logic [1:0] sh_channel,
    input wire logic result_strobe,
    input wire logic [asq_pkg::PTR_W-1:0] buf_pointer,
    input wire logic [asq_pkg::DADDR_W-1:0] dma_address,
    input wire logic converter_irq_flag,
    input wire logic dma_request
);
    import asq_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // a switch-off also ends conversion, so it is excluded
    sequence s_conv_end;
        $fell(converting) ##0 (converter_on && $past(converter_on));
    endsequence
    sequence s_strobe_irq;
        result_strobe ##0 converter_irq_flag;
    endsequence
    a_done_clr_start: assert property ($rose(converting) |-> !conv_done && !sample_phase_bit)
        else $error("done not cleared at conversion start");
    a_done_set_end: assert property (s_conv_end |-> conv_done)
        else $error("done not set at conversion end");
    a_done_holds: assert property (conv_done && !converting && !done_clear_write && converter_on
        |=> conv_done || converting)
        else $error("done dropped without cause");
    a_done_sw_clear: assert property (done_clear_write && !converting |=> !conv_done)
        else $error("done not cleared by software");
    a_clear_no_abort: assert property (done_clear_write && converting && converter_on
        |=> converting || result_strobe)
        else $error("clearing done disturbed conversion");
    a_irq_single: assert property (converter_irq_flag |=> !converter_irq_flag)
        else $error("irq flag pulse longer than one cycle");
    a_irq_dma_pair: assert property ((converter_irq_flag || dma_request)
        |-> dma_request == (converter_irq_flag && dma_present))
        else $error("dma request not paired with irq flag");
    a_irq_count_point: assert property (converter_irq_flag |-> s_strobe_irq ##0 buf_pointer == '0)
        else $error("irq flag not at a count point");
    a_ordered_addr: assert property (result_strobe && dma_present && dma_build_order_select
        |-> dma_address == DADDR_W'($past(buf_pointer)))
        else $error("ordered dma address differs from buffer pointer");
    a_one_sh_12b: assert property (resolution_select && result_strobe |-> sh_channel == 2'h0)
        else $error("12-bit mode used a second holding channel");
    a_auto_resample: assert property (s_conv_end ##0 auto_sample_start |-> ##[0:1] sample_phase_bit)
        else $error("auto start did not resume sampling");
endmodule
bind asq_sequencer asq_sequencer_sva u_sva (.clk, .rst_n, .converter_on, .resolution_select,
    .auto_sample_start, .done_clear_write, .dma_present, .dma_build_order_select,
    .sample_phase_bit, .conv_done, .converting, .sh_channel, .result_strobe, .buf_pointer,
    .dma_address, .converter_irq_flag, .dma_request);

/* File: verif/asq_sequencer_test.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module asq_sequencer_test;
    import asq_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, converter_on = 1'b0, resolution_select = 1'b0;
    logic auto_sample_start = 1'b0, input_scan_enable = 1'b0, sample_start_write = 1'b0;
    logic done_clear_write = 1'b0, dma_present = 1'b0, dma_build_order_select = 1'b0;
    logic [3:0] trg = 4'h0, samples_per_increment = 4'h0, ch0_input_select = 4'h0;
    logic [3:0] buf_read_index = 4'h0, ch0_input_active, buf_pointer;
    logic [1:0] result_format_select = 2'h0, channel_count_select = 2'h0, sh_channel;
    logic [2:0] convert_trigger_source = 3'h0, dma_buf_size_log2 = 3'h0;
    logic [4:0] auto_sample_cycles = 5'h02;
    logic [11:0] sar_code = 12'h000;
    logic [12:0] scan_select = 13'h0, pin_analog_config = 13'h0, peer_pin_analog_config = 13'h0;
    logic [12:0] pin_level = 13'h0, digital_in;
    logic sample_phase_bit, conv_done, converting, result_strobe, converter_irq_flag, dma_request;
    logic [15:0] result_word_first, buf_read_data, read_word;
    logic [7:0] dma_address, last_addr;
    int req_count, irq_count, err_total = 0, checked = 0;
    logic [2:0] trig_tab [4] = '{TRIG_SOFT, TRIG_EXT_PIN, TRIG_TIMER_A, TRIG_TIMER_B};
    logic [15:0] fmt_tab [4] = '{16'h03a5, 16'hfba5, 16'h0000, 16'h0000};
    logic [15:0] addr_tab [4] = '{16'h000c, 16'h0018, 16'h000c, 16'h000d};

    always #25 clk = ~clk;

    asq_sequencer uut (.clk, .rst_n, .converter_on, .resolution_select, .result_format_select,
        .convert_trigger_source, .auto_sample_start, .channel_count_select,
        .samples_per_increment, .input_scan_enable, .scan_select, .ch0_input_select,
        .auto_sample_cycles, .sample_start_write, .sample_end_write(trg[0]), .done_clear_write,
        .ext_pin_edge(trg[1]), .timer_a_match(trg[2]), .timer_b_match(trg[3]), .dma_present,
        .dma_build_order_select, .dma_buf_size_log2, .sar_code, .buf_read_index,
        .pin_analog_config, .peer_pin_analog_config, .pin_level, .sample_phase_bit, .conv_done,
        .converting, .ch0_input_active, .sh_channel, .result_strobe, .result_word_first,
        .buf_read_data, .buf_pointer, .dma_address, .converter_irq_flag, .dma_request,
        .digital_in);

    asq_dma_model partner (.clk, .rst_n, .dma_request, .converter_irq_flag, .dma_address,
        .result_word_first, .req_count, .irq_count, .last_addr, .read_word);

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // which: 0 waits for a result strobe, 1 for the sample phase
    task automatic wait_for(input int which);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if (((which == 0) ? result_strobe : sample_phase_bit) === 1'b1) return;
        end
        err_total++;
        $display("[FAIL] wait %0d expected event seen none", which);
        test_done();
    endtask

    task automatic run_manual(input logic [2:0] t, input logic [11:0] code);
        @(posedge clk);
        sar_code <= code;
        // stale completion cleared before the sample bit
        done_clear_write <= 1'b1;
        @(posedge clk);
        done_clear_write <= 1'b0;
        sample_start_write <= 1'b1;
        @(posedge clk);
        sample_start_write <= 1'b0;
        wait_for(1);
        chk("done cleared", 16'h0, {15'h0, conv_done});
        chk("not converting", 16'h0, {15'h0, converting});
        @(posedge clk);
        trg <= {t == TRIG_TIMER_B, t == TRIG_TIMER_A, t == TRIG_EXT_PIN, t == TRIG_SOFT};
        @(posedge clk);
        trg <= 4'h0;
        wait_for(0);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("done after reset", 16'h0, {15'h0, conv_done});
        @(posedge clk);
        samples_per_increment <= 4'h1;
        pin_analog_config <= 13'h1fff;
        peer_pin_analog_config <= 13'h0f0f;
        pin_level <= 13'h1234;
        @(posedge clk);
        converter_on <= 1'b1;
        run_manual(TRIG_SOFT, 12'h2a5);
        chk("word 10b", 16'h02a5, result_word_first);
        chk("done set", 16'h1, {15'h0, conv_done});
        chk("pointer one", 16'h1, {12'h0, buf_pointer});
        chk("digital in", 16'h0204, {3'h0, digital_in});
        run_manual(TRIG_SOFT, 12'h15a);
        chk("irq flag", 16'h1, {15'h0, converter_irq_flag});
        chk("no dma request", 16'h0, {15'h0, dma_request});
        chk("pointer wrap", 16'h0, {12'h0, buf_pointer});
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            buf_read_index <= 4'(k);
            repeat (2) @(posedge clk);
            #1;
            chk("buffer", (k == 0) ? 16'h02a5 : 16'h015a, buf_read_data);
        end
        chk("irq count", 16'h1, 16'(irq_count));
        // 12-bit, every format, each trigger but auto, dma in conversion order
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            converter_on <= 1'b0;
            @(posedge clk);
            resolution_select <= 1'b1;
            result_format_select <= 2'(i);
            convert_trigger_source <= trig_tab[i];
            samples_per_increment <= 4'h0;
            dma_present <= 1'b1;
            dma_build_order_select <= 1'b1;
            @(posedge clk);
            converter_on <= 1'b1;
            run_manual(trig_tab[i], 12'h3a5);
            chk("word 12b", fmt_tab[i], result_word_first);
            chk("dma request", 16'h1, {15'h0, dma_request});
            @(posedge clk);
            #1;
            chk("dma count", 16'(i + 1), 16'(req_count));
            chk("dma read", fmt_tab[i], read_word);
            chk("ordered addr", 16'h0, {8'h0, last_addr});
        end
        // auto scan of inputs 6 and 12, scatter slots of two words
        @(posedge clk);
        converter_on <= 1'b0;
        @(posedge clk);
        resolution_select <= 1'b0;
        convert_trigger_source <= TRIG_AUTO;
        samples_per_increment <= 4'h2;
        input_scan_enable <= 1'b1;
        scan_select <= 13'h1040;
        dma_build_order_select <= 1'b0;
        dma_buf_size_log2 <= 3'h1;
        auto_sample_start <= 1'b1;
        @(posedge clk);
        converter_on <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wait_for(0);
            chk("scatter addr", addr_tab[k], {8'h0, dma_address});
            chk("scan input", addr_tab[k] >> 1, {12'h0, ch0_input_active});
        end
        test_done();
    end
endmodule
